/* src/dpsc_chains.sv */
/*
  Data register scan chains: bypass, identification and one access chain shared by port and AP access.
  Assumes a separate TAP controller drives state flags and the instruction,
  and the register bank answers requests with one completion pulse.
*/
module dpsc_chains
  import dpsc_pkg::*;
#(
  parameter logic [3:0] VERSION = ID_VERSION,
  parameter logic [15:0] PART_NUMBER = ID_PART,
  parameter logic [3:0] CONT_COUNT = ID_CONT,
  parameter logic [6:0] IDENT_CODE = ID_IDENT
) (
  // Clock and control
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Test access pins and TAP state flags
  input wire logic test_clk,
  input wire logic serial_data_in,
  input wire logic [3:0] ir_value,
  input wire logic tap_capture,
  input wire logic tap_shift,
  input wire logic tap_update,
  output logic serial_data_out,
  // Register bank status
  input wire logic sticky_any,
  input wire logic overrun_detect_enable,
  input wire logic [1:0] transfer_mode_field,
  input wire logic [3:0] select_bank,
  // Register requests
  output logic req_valid,
  output dpsc_req_t req,
  input wire dpsc_resp_t resp,
  // Sticky flag set pulses
  output logic set_sticky_overrun,
  output logic set_sticky_compare
);
  typedef enum logic [1:0] {
    TXN_IDLE = 2'b01,
    TXN_BUSY = 2'b10
  } dpsc_txn_t;

  logic tck_s, sdi_s, cap_s, sh_s, upd_s;
  logic [3:0] ir_s;
  logic tck_rise, tck_fall;
  logic bypass_stage;
  logic [ID_LEN-1:0] id_chain;
  logic [CHAIN_LEN-1:0] acc_chain;
  logic wait_flag;
  dpsc_txn_t txn;
  logic [31:0] captured_read_value;
  dpsc_req_t next_req;
  logic [31:0] id_word;
  logic is_acc, is_ap, is_id, is_byp, do_issue, match;

  // ==========================================================
  // Pin synchronisers and edge finding
  dpsc_sync #(.W(9)) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in({test_clk, serial_data_in, ir_value, tap_capture, tap_shift,
               tap_update}),
    .sync_out({tck_s, sdi_s, ir_s, cap_s, sh_s, upd_s})
  );

  dpsc_edge u_edge (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .level(tck_s),
    .rise(tck_rise),
    .fall(tck_fall)
  );

  // ==========================================================
  // Chain selection from the instruction
  function automatic logic sel_is(input logic [3:0] ir, input logic [3:0] c);
    sel_is = (ir == c);
  endfunction

  // Any other code, abort included, falls to bypass here
  assign is_acc = sel_is(ir_s, IR_PORT_ACC) | sel_is(ir_s, IR_AP_ACC);
  assign is_ap = sel_is(ir_s, IR_AP_ACC);
  assign is_id = sel_is(ir_s, IR_IDENT);
  assign is_byp = ~is_acc & ~is_id;

  // Identification word assembly
  assign id_word = {VERSION, PART_NUMBER, CONT_COUNT, IDENT_CODE, ID_ONE};

  // ==========================================================
  // Bypass stage
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bypass_stage <= 1'h0;
    end else if (clk_en && tck_rise && is_byp) begin
      if (cap_s) begin
        bypass_stage <= 1'h0;
      end else if (sh_s) begin
        bypass_stage <= sdi_s;
      end
    end
  end

  // ==========================================================
  // Identification chain, nothing done on update
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      id_chain <= '0;
    end else if (clk_en && tck_rise && is_id) begin
      if (cap_s) begin
        id_chain <= id_word;
      end else if (sh_s) begin
        id_chain <= {sdi_s, id_chain[ID_LEN-1:1]};
      end
    end
  end

  // ==========================================================
  // Access chain capture and shift
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      acc_chain <= '0;
      wait_flag <= 1'h0;
    end else if (clk_en && tck_rise && is_acc) begin
      if (cap_s) begin
        // Result and ack
        acc_chain[DATA_MSB:DATA_LSB] <= captured_read_value;
        if (txn == TXN_BUSY) begin
          acc_chain[ACK_MSB:ACK_LSB] <= ACK_WAIT;
          wait_flag <= 1'h1;
        end else begin
          acc_chain[ACK_MSB:ACK_LSB] <= ACK_OK;
          wait_flag <= 1'h0;
        end
      end else if (sh_s) begin
        acc_chain <= {sdi_s, acc_chain[CHAIN_LEN-1:1]};
      end
    end
  end

  // ==========================================================
  // Serial output changes on the falling test clock edge
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      serial_data_out <= 1'h0;
    end else if (clk_en && tck_fall) begin
      if (is_acc) begin
        serial_data_out <= acc_chain[0];
      end else if (is_id) begin
        serial_data_out <= id_chain[0];
      end else begin
        serial_data_out <= bypass_stage;
      end
    end
  end

  // ==========================================================
  // Request decode at update
  // Update after WAIT or with sticky set on AP issues nothing
  assign do_issue = clk_en && tck_rise && upd_s && is_acc && !wait_flag
                    && !(is_ap && sticky_any);

  always_comb begin
    next_req = '0;
    next_req.ap_sel = is_ap;
    next_req.read_not_write = acc_chain[RNW_BIT];
    next_req.addr = acc_chain[ADDR_MSB:ADDR_LSB];
    next_req.bank = is_ap ? select_bank : 4'h0;
    next_req.write_payload = acc_chain[DATA_MSB:DATA_LSB];
    next_req.mode = TRN_NORMAL;
    // Pushed operations turn a write into a read and compare
    if (is_ap && transfer_mode_field != TRN_NORMAL) begin
      next_req.read_not_write = 1'h1;
      next_req.mode = transfer_mode_field;
    end
  end

  // ==========================================================
  // Request output register, one cycle valid pulse
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      req_valid <= 1'h0;
      req <= '0;
    end else if (clk_en) begin
      req_valid <= do_issue;
      if (do_issue) begin
        req <= next_req;
      end
    end
  end

  // ==========================================================
  // Pending tracker: busy until bank signals completion
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      txn <= TXN_IDLE;
    end else if (clk_en) begin
      case (txn)
        TXN_IDLE: begin
          if (do_issue) begin
            txn <= TXN_BUSY;
          end
        end
        TXN_BUSY: begin
          if (resp.done) begin
            txn <= TXN_IDLE;
          end
        end
        default: begin
          txn <= TXN_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Read result holding; a later read returns it
  assign match = (resp.rdata == req.write_payload);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      captured_read_value <= '0;
    end else if (clk_en && txn == TXN_BUSY && resp.done) begin
      if (req.read_not_write && resp.ok && req.mode == TRN_NORMAL) begin
        captured_read_value <= resp.rdata;
      end
    end
  end

  // ==========================================================
  // Sticky flag set pulses
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      set_sticky_overrun <= 1'h0;
      set_sticky_compare <= 1'h0;
    end else if (clk_en) begin
      set_sticky_overrun <= tck_rise && cap_s && is_acc
                            && txn == TXN_BUSY
                            && overrun_detect_enable;
      set_sticky_compare <= txn == TXN_BUSY && resp.done && resp.ok
                            && ((req.mode == TRN_COMPARE && match)
                            || (req.mode == TRN_VERIFY && !match));
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  AST_ACK_LEGAL: assert property (
    clk_en && tck_rise && cap_s && is_acc |=>
      acc_chain[ACK_MSB:ACK_LSB] == ACK_OK
      || acc_chain[ACK_MSB:ACK_LSB] == ACK_WAIT)
    else $error("ack code not legal");

  AST_WAIT_BUSY: assert property (
    clk_en && tck_rise && cap_s && is_acc && txn == TXN_BUSY |=>
      acc_chain[ACK_MSB:ACK_LSB] == ACK_WAIT && wait_flag)
    else $error("busy capture did not return wait");

  AST_ORUN_SET: assert property (
    clk_en && tck_rise && cap_s && is_acc && txn == TXN_BUSY
      && overrun_detect_enable |=> set_sticky_overrun)
    else $error("overrun flag not set");

  AST_NO_REQ_WAIT: assert property (
    tck_rise && upd_s && wait_flag |=> !req_valid)
    else $error("request issued after wait");

  AST_STICKY_DROP: assert property (
    tck_rise && upd_s && is_ap && sticky_any |=> !req_valid)
    else $error("AP request issued with sticky set");

  AST_BYPASS_ZERO: assert property (
    clk_en && tck_rise && cap_s && is_byp |=> !bypass_stage)
    else $error("bypass did not capture zero");

  AST_ID_LOAD: assert property (
    clk_en && tck_rise && cap_s && is_id |=> id_chain[0] == ID_ONE
      && id_chain == $past(id_word))
    else $error("id word not captured");

  AST_REQ_BUSY: assert property (
    req_valid |-> txn == TXN_BUSY)
    else $error("request without pending state");

  AST_WRITE_REQ: assert property (
    do_issue && !acc_chain[RNW_BIT] && !(is_ap
      && transfer_mode_field != TRN_NORMAL) |=>
      req_valid && !req.read_not_write
      && req.write_payload == $past(acc_chain[DATA_MSB:DATA_LSB]))
    else $error("write request malformed");

  // Bypass stage takes the input bit on each shift edge
  AST_BYPASS_SHIFT: assert property (
    clk_en && tck_rise && sh_s && !cap_s && is_byp |=>
      bypass_stage == $past(sdi_s))
    else $error("bypass stage missed the input bit");

  // Identification chain moves one place toward the output
  AST_ID_SHIFT: assert property (
    clk_en && tck_rise && sh_s && !cap_s && is_id |=>
      id_chain == {$past(sdi_s), $past(id_chain[ID_LEN-1:1])})
    else $error("id chain did not shift");

  // Capture loads the held read value above the ack bits
  AST_ACC_DATA: assert property (
    clk_en && tck_rise && cap_s && is_acc |=>
      acc_chain[DATA_MSB:DATA_LSB] == $past(captured_read_value))
    else $error("access chain missed the read value");

  // Access chain shifts toward the output, ack bits first
  AST_ACC_SHIFT: assert property (
    clk_en && tck_rise && sh_s && !cap_s && is_acc |=>
      acc_chain == {$past(sdi_s), $past(acc_chain[CHAIN_LEN-1:1])})
    else $error("access chain did not shift");

  // Read direction bit gives a read request
  AST_READ_REQ: assert property (
    do_issue && acc_chain[RNW_BIT] |=> req_valid && req.read_not_write)
    else $error("read request malformed");

  // Port requests carry no bank, access port ones the select bits
  AST_REQ_ADDR: assert property (
    do_issue |=> req.ap_sel == $past(is_ap)
      && req.addr == $past(acc_chain[ADDR_MSB:ADDR_LSB])
      && req.bank == ($past(is_ap) ? $past(select_bank) : 4'h0))
    else $error("request address malformed");

  // Pushed modes always read and carry the mode along
  AST_PUSHED_READ: assert property (
    do_issue && is_ap && transfer_mode_field != TRN_NORMAL |=>
      req.read_not_write && req.mode == $past(transfer_mode_field))
    else $error("pushed request not a read");

  // No request from bypass or identification updates
  AST_NO_REQ_OTHER: assert property (
    tck_rise && upd_s && !is_acc |=> !req_valid)
    else $error("request from a chain without update");

  // Serial output moves only on a falling test clock edge
  AST_SDO_HOLD: assert property (
    !(clk_en && tck_fall) |=> $stable(serial_data_out))
    else $error("serial output moved between edges");

  // Completion returns the tracker to idle
  AST_DONE_IDLE: assert property (
    clk_en && txn == TXN_BUSY && resp.done |=> txn == TXN_IDLE)
    else $error("tracker stayed busy after completion");

  // Request valid is a single cycle pulse
  AST_REQ_PULSE: assert property (
    req_valid |=> !req_valid)
    else $error("request valid longer than a cycle");
endmodule

/* src/dpsc_edge.sv */
/*
  Finds rising and falling edges of the synchronised test clock.
  Assumes input already passed the synchroniser.
*/
module dpsc_edge
  import dpsc_pkg::*;
(
  // Clock and control
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Level in, edge pulses out
  input wire logic level,
  output logic rise,
  output logic fall
);
  logic prev;
  // ==========================================================
  // Delay stage for comparison
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prev <= 1'h0;
    end else if (clk_en) begin
      prev <= level;
    end
  end
  assign rise = level & ~prev;
  assign fall = ~level & prev;
endmodule

/* src/dpsc_pkg.sv */
/*
  Shared constants and carriers for the debug port data scan chains.
  Assumes a single system clock; all pins are sampled by the chain block.
*/
package dpsc_pkg;
  // ==========================================================
  // Instruction codes
  localparam logic [3:0] IR_PORT_ACC = 4'ha;
  localparam logic [3:0] IR_AP_ACC = 4'hb;
  localparam logic [3:0] IR_IDENT = 4'he;
  // ==========================================================
  // Chain layout
  localparam int CHAIN_LEN = 35;
  localparam int ID_LEN = 32;
  localparam int ACK_LSB = 0;
  localparam int ACK_MSB = 2;
  localparam int DATA_LSB = 3;
  localparam int DATA_MSB = 34;
  localparam int RNW_BIT = 0;
  localparam int ADDR_LSB = 1;
  localparam int ADDR_MSB = 2;
  localparam logic [2:0] ACK_OK = 3'h2;
  localparam logic [2:0] ACK_WAIT = 3'h1;
  // ==========================================================
  // Transfer mode field codes
  localparam logic [1:0] TRN_NORMAL = 2'h0;
  localparam logic [1:0] TRN_VERIFY = 2'h1;
  localparam logic [1:0] TRN_COMPARE = 2'h2;
  // ==========================================================
  // Identification word, values arbitrary
  localparam logic [3:0] ID_VERSION = 4'h1;
  localparam logic [15:0] ID_PART = 16'h0c5e;
  localparam logic [3:0] ID_CONT = 4'h0;
  localparam logic [6:0] ID_IDENT = 7'h15;
  localparam logic ID_ONE = 1'h1;
  // ==========================================================
  // Register request and completion carriers
  typedef struct packed {
    logic ap_sel;
    logic read_not_write;
    logic [1:0] mode;
    logic [3:0] bank;
    logic [1:0] addr;
    logic [31:0] write_payload;
  } dpsc_req_t;
  typedef struct packed {
    logic done;
    logic ok;
    logic [31:0] rdata;
  } dpsc_resp_t;
endpackage

/* src/dpsc_sync.sv */
/*
  Two flop synchroniser for pin level inputs.
  Assumes inputs are asynchronous to ref_clk.
*/
module dpsc_sync
  import dpsc_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and control
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta;
  // ==========================================================
  // First stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meta <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

/* tb/dpsc_dbg.sv */
/*
  Debugger stand-in: drives test clock, state flags and serial data.
  Assumes the port samples these pins with its own faster clock.
*/
module dpsc_dbg (
  // Pins toward the port
  output logic test_clk,
  output logic serial_data_in,
  output logic [3:0] ir_value,
  output logic tap_capture,
  output logic tap_shift,
  output logic tap_update,
  // Pin from the port
  input wire logic serial_data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Idle levels, clock parked low outside scans
  initial begin
    test_clk = 1'b0;
    serial_data_in = 1'b0;
    ir_value = 4'hf;
    tap_capture = 1'b0;
    tap_shift = 1'b0;
    tap_update = 1'b0;
  end
  // One test clock period of 125 ns
  task automatic tck();
    #62.5 test_clk = 1'b1;
    #62.5 test_clk = 1'b0;
  endtask
  // Capture, n shifts LSB first, update, then a quiet gap
  task automatic scan(input logic [3:0] ir, input int n,
                      input logic [34:0] din, output logic [34:0] dout);
    dout = '0;
    ir_value = ir;
    tap_capture = 1'b1;
    tck();
    tap_capture = 1'b0;
    tap_shift = 1'b1;
    for (int i = 0; i < n; i++) begin
      serial_data_in = din[i];
      #62.5 dout[i] = serial_data_out;
      test_clk = 1'b1;
      #62.5 test_clk = 1'b0;
    end
    tap_shift = 1'b0;
    tap_update = 1'b1;
    serial_data_in = ~serial_data_in; // Released line shows the inverse
    tck();
    tap_update = 1'b0;
    #250;
  endtask
endmodule

/* tb/tb.sv */
/*
  Self-checking bench for the scan chains, with a register bank stand-in.
  Assumes dpsc_pkg, the design files and dpsc_dbg are compiled first.
*/
module tb
  import dpsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Signals and bench state
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic test_clk, serial_data_in, serial_data_out;
  logic tap_capture, tap_shift, tap_update;
  logic [3:0] ir_value, select_bank;
  logic sticky_any, ovr_en, req_valid, set_ovr, set_cmp, rv, so, sc;
  logic [1:0] tmode, a;
  dpsc_req_t req, r;
  dpsc_resp_t resp;
  logic [31:0] mem [0:127];
  logic [31:0] v;
  logic [6:0] lidx;
  logic [34:0] d;
  int err_count = 0, cmp_count = 0, seed = 4008, cycles = 0;
  int cnt = 0, dly = 2, n_req = 0, n_ovr = 0, n_cmp = 0, k, o, c;
  // Identification values are arbitrary
  localparam logic [31:0] EXP_ID = {4'h3, 16'h1a2b, 4'h2, 7'h5c, 1'b1};
  localparam logic [3:0] BYP_IR [5] = '{4'hf, 4'h8, 4'h9, 4'h0, 4'hc};
  // ==========================================================
  // Design, debugger and clock
  dpsc_chains #(
    .VERSION(4'h3), .PART_NUMBER(16'h1a2b), .CONT_COUNT(4'h2),
    .IDENT_CODE(7'h5c)
  ) uut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1),
    .test_clk(test_clk), .serial_data_in(serial_data_in),
    .ir_value(ir_value), .tap_capture(tap_capture),
    .tap_shift(tap_shift), .tap_update(tap_update),
    .serial_data_out(serial_data_out), .sticky_any(sticky_any),
    .overrun_detect_enable(ovr_en), .transfer_mode_field(tmode),
    .select_bank(select_bank), .req_valid(req_valid), .req(req),
    .resp(resp), .set_sticky_overrun(set_ovr), .set_sticky_compare(set_cmp)
  );
  dpsc_dbg u_dbg (
    .test_clk(test_clk), .serial_data_in(serial_data_in),
    .ir_value(ir_value), .tap_capture(tap_capture),
    .tap_shift(tap_shift), .tap_update(tap_update),
    .serial_data_out(serial_data_out)
  );
  // System clock, 100 MHz
  always #5 ref_clk = ~ref_clk;
  // Bank stand-in: stores writes, answers after dly cycles, counts pulses
  always @(posedge ref_clk) begin
    #1;
    rv = req_valid;
    r = req;
    so = set_ovr;
    sc = set_cmp;
    cycles++;
    n_ovr += so;
    n_cmp += sc;
    resp.done = 1'b0;
    if (rv) begin
      n_req++;
      lidx = {r.ap_sel, r.bank, r.addr};
      if (!r.read_not_write)
        mem[lidx] = r.write_payload;
      cnt = dly;
    end else if (cnt > 0) begin
      cnt--;
      if (cnt == 0)
        resp = '{done: 1'b1, ok: 1'b1, rdata: mem[lidx]};
    end
    if (cycles > 30000) begin
      err_count++;
      give_verdict();
    end
  end
  // ==========================================================
  // Helpers
  task automatic check(input string what, input logic [47:0] seen,
                       input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic acc(input logic [3:0] ir, input logic [34:0] din);
    u_dbg.scan(ir, 35, din, d);
  endtask
  task automatic sync();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic give_verdict();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================================
  // Test sequence
  initial begin
    sticky_any = 1'b0;
    ovr_en = 1'b0;
    tmode = TRN_NORMAL;
    select_bank = 4'h0;
    resp = '0;
    foreach (mem[i])
      mem[i] = $random(seed);
    repeat (16) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    check("req_valid", req_valid, 0);
    foreach (BYP_IR[i]) begin
      v = $random(seed);
      u_dbg.scan(BYP_IR[i], 8, 35'(v), d);
      check("bypass", d[7:0], {v[6:0], 1'b0});
    end
    u_dbg.scan(IR_IDENT, 32, 35'($random(seed)), d);
    check("identification_word", d[31:0], EXP_ID);
    check("requests", n_req, 0);
    $display("Test bypass and identification done");
    v = $random(seed);
    acc(IR_PORT_ACC, {v, 2'h1, 1'b0}); // Stale value dropped
    check("ack", d[2:0], ACK_OK);
    check("dp write", req, {2'h0, TRN_NORMAL, 4'h0, 2'h1, v});
    acc(IR_PORT_ACC, {32'h0, 2'h1, 1'b1}); // Status read
    check("ack", d[2:0], ACK_OK);
    acc(IR_PORT_ACC, {32'h0, 2'h3, 1'b1}); // Buffer read ends run
    check("read value", d[34:3], v);
    check("dp read", {req.read_not_write, req.addr}, 3'h7);
    $display("Test pipelined port access done");
    for (int m = 0; m < 3; m++) begin
      sync();
      select_bank = 4'($random(seed));
      a = 2'($random(seed));
      v = $random(seed);
      acc(IR_AP_ACC, {v, a, 1'b0});
      check("ap req", req, {2'h2, TRN_NORMAL, select_bank, a, v});
      sync();
      tmode = 2'(m);
      c = n_cmp;
      // Verify sees a changed payload, compare an equal one
      acc(IR_AP_ACC, {v ^ 32'(m == 1), a, 1'b0}); // Direction 0
      check("pushed read", req.read_not_write, m != 0);
      acc(IR_PORT_ACC, {32'h0, 2'h3, 1'b1});
      check("compare", n_cmp - c, tmode != TRN_NORMAL);
      sync();
      tmode = TRN_NORMAL;
    end
    $display("Test access port modes done");
    sync();
    dly = 200;
    ovr_en = 1'b1;
    acc(IR_PORT_ACC, {32'h0, 2'h2, 1'b1});
    k = n_req;
    o = n_ovr;
    acc(IR_PORT_ACC, {32'h0, 2'h1, 1'b0});
    check("ack", d[2:0], ACK_WAIT);
    check("overrun", n_ovr - o, 1);
    check("requests", n_req - k, 0);
    sync();
    dly = 2;
    acc(IR_PORT_ACC, {32'h0, 2'h3, 1'b1});
    check("ack", d[2:0], ACK_OK);
    check("read value", d[34:3], mem[2]);
    $display("Test wait and overrun done");
    sync();
    ovr_en = 1'b0;
    sticky_any = 1'b1;
    k = n_req;
    acc(IR_AP_ACC, {v, 2'h0, 1'b0});
    check("requests", n_req - k, 0);
    acc(IR_PORT_ACC, {32'h0, 2'h3, 1'b1});
    check("ack", d[2:0], ACK_OK);
    check("requests", n_req - k, 1);
    $display("Test sticky discard done");
    give_verdict();
  end
endmodule
